/* File: logic/asp_consts.svh */
// constants of the two-wire control slave: address, subaddress map, widths
// assumes inclusion by asp_pkg users and by the design modules by bare name
`ifndef ASP_CONSTS_SVH
`define ASP_CONSTS_SVH

// upper five bits of the 7-bit slave address
`define ASP_ADDR_HI5   5'h0d
// subaddress and data widths
`define ASP_SUB_W      12
`define ASP_WORD_W     40
// bit counter: eight data bits then the acknowledge slot
`define ASP_BIT_LAST   4'h7
`define ASP_BIT_ACK    4'h8
// subaddress map: three regions, bounds and word length in bytes
`define ASP_NREG       3
`define ASP_R0_LO      12'h000
`define ASP_R0_HI      12'h3ff
`define ASP_R0_LEN     3'h4
`define ASP_R1_LO      12'h400
`define ASP_R1_HI      12'h5ff
`define ASP_R1_LEN     3'h5
`define ASP_R2_LO      12'h800
`define ASP_R2_HI      12'h83f
`define ASP_R2_LEN     3'h2
// highest valid subaddress, where bursts stop advancing
`define ASP_SUB_TOP    12'h83f

`endif

/* File: logic/asp_pkg.sv */
// types of the two-wire control slave
// assumes asp_consts.svh for numeric constants
package asp_pkg;

   // -----------------------------------------------------------------
   // link-side protocol states
   // -----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_ADDR  = 3'b001,
      ST_SUBH  = 3'b010,
      ST_SUBL  = 3'b011,
      ST_WDATA = 3'b100,
      ST_RDATA = 3'b101
   } asp_state_t;

endpackage : asp_pkg

/* File: logic/asp_map.sv */
// subaddress decoder: validity, word length and top-of-map flag
// assumes a combinational use from the link-side state machine
`timescale 1ns/1ps
`include "asp_consts.svh"

module asp_map
   import asp_pkg::*;
(
   input  wire logic [11:0] sub,
   output logic             valid,
   output logic [2:0]       len,
   output logic             last
);

   localparam logic [11:0] LO [`ASP_NREG] = '{`ASP_R0_LO, `ASP_R1_LO, `ASP_R2_LO};
   localparam logic [11:0] HI [`ASP_NREG] = '{`ASP_R0_HI, `ASP_R1_HI, `ASP_R2_HI};
   localparam logic [2:0]  LN [`ASP_NREG] = '{`ASP_R0_LEN, `ASP_R1_LEN, `ASP_R2_LEN};

   logic [`ASP_NREG-1:0] hit;

   // -----------------------------------------------------------------
   // region match, one comparator pair per region
   // -----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < `ASP_NREG; g++) begin : g_reg
         assign hit[g] = (sub >= LO[g]) && (sub <= HI[g]);
      end
   endgenerate

   // range lookup
   // regions do not overlap, so the last hit found is the only one
   always_comb begin
      valid = 1'b0;
      len   = 3'h1;
      for (int i = 0; i < `ASP_NREG; i++) begin
         if (hit[i]) begin
            valid = 1'b1;
            len   = LN[i];
         end
      end
   end

   assign last = (sub == `ASP_SUB_TOP);

endmodule : asp_map

/* File: logic/asp_i2c_slave.sv */
// two-wire control slave: address match, subaddress, burst read and write
// assumes an open-drain SDA resolved outside, SCL as link clock,
// and a word store that answers RD_DATA in the cycle RD_REQ is high
//
// What this block does
// - acts only as a slave, never starts a transfer itself
// - answers address 01101 plus the two address pins
// - last bit of address byte: 1 reads, 0 writes
// - idle port watches for SDA falling while SCL is high
// - takes eight bits MSB first, acks own address on ninth clock
// - foreign address releases bus, waits for next start
// - transfer lasts until SDA rises while SCL is high
// - stop out of sequence sends port to idle at once; start restarts the address phase
// - invalid subaddress gets no ack and returns to idle
// - subaddress advances after each complete word until stop, holding at the top location
// - word length of one to five bytes sets the advance point
// - every written byte up to the top location is acked on the ninth clock
// - read past top keeps sending top location until master nack
// - write past top discards byte, nacks, returns to idle
// - read turns SDA around; master acks each byte for more
// - two subaddress bytes follow address, high first, then data
// - subaddress is 12 bits, top nibble of high byte zero
// - port is enabled when boot pin is low at power-up
`timescale 1ns/1ps
`include "asp_consts.svh"

module asp_i2c_slave
   import asp_pkg::*;
(
   input  wire logic        MCLK,
   input  wire logic        RESETN,
   input  wire logic        SCL,
   input  wire logic        SDA_IN,
   output logic             SDA_OUT,
   output logic             SDA_OE,
   input  wire logic        SLAVE_ADDR_PIN_LOW,
   input  wire logic        SLAVE_ADDR_PIN_HIGH,
   input  wire logic        BOOT_SEL,
   output logic             WR_STROBE,
   output logic [11:0]      WR_ADDR,
   output logic [2:0]       WR_BYTE,
   output logic [7:0]       WR_DATA,
   output logic             RD_REQ,
   output logic [11:0]      RD_ADDR,
   input  wire logic [39:0] RD_DATA,
   output logic             PORT_ACTIVE
);

   // -----------------------------------------------------------------
   // system domain: reset release, pin synchronisers, frame detect
   // -----------------------------------------------------------------
   logic        rst_s1_r, rst_n;
   logic [4:0]  pin_s1_r, pin_s2_r;    // boot, addr hi, addr lo, sda, scl
   logic        sda_d_r, boot_done_r, i2c_mode_r, link_en_r;
   logic        start_det, stop_det;
   logic        wt_s1_r, wt_s2_r, wt_d_r, ft_s1_r, ft_s2_r, ft_d_r;
   logic        wr_stb_r, rd_req_r;
   logic [11:0] wr_addr_r, rd_addr_r;
   logic [2:0]  wr_byte_r;
   logic [7:0]  wr_data_r;
   logic [39:0] rd_word_r;

   // reset released through two flops
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         rst_s1_r <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n    <= rst_s1_r;
      end
   end

   // pin synchronisers, data only, so no reset needed
   always_ff @(posedge MCLK) begin
      pin_s1_r <= {BOOT_SEL, SLAVE_ADDR_PIN_HIGH, SLAVE_ADDR_PIN_LOW, SDA_IN, SCL};
      pin_s2_r <= pin_s1_r;
      sda_d_r  <= pin_s2_r[1];
   end

   assign start_det = pin_s2_r[0] & sda_d_r & ~pin_s2_r[1];
   assign stop_det  = pin_s2_r[0] & ~sda_d_r & pin_s2_r[1];

   // boot strap caught once after reset release
   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         boot_done_r <= 1'b0;
         i2c_mode_r  <= 1'b0;
      end else if (!boot_done_r) begin
         boot_done_r <= 1'b1;
         i2c_mode_r  <= ~pin_s2_r[4];
      end
   end

   // stop or reset holds the link logic in reset
   // link_en_r is the asynchronous reset of the SCL-domain state, shift and drive flops; it falls on
   // stop and rises on start when i2c_mode_r is set, well before the first data edge
   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         link_en_r <= 1'b0;
      end else if (stop_det) begin
         link_en_r <= 1'b0;
      end else if (start_det) begin
         link_en_r <= i2c_mode_r;
      end
   end

   // -----------------------------------------------------------------
   // link domain on SCL
   // -----------------------------------------------------------------
   asp_state_t  st_r, st_nxt;
   logic [3:0]  cnt_r, cnt_nxt;
   logic [7:0]  sh_r, sh_nxt, tx_r, tx_nxt, byte_in, wd_nxt, wd_r;
   logic        rw_r, rw_nxt, ovr_r, ovr_nxt, drv_r, drv_nxt;
   logic [11:0] sub_r, sub_nxt, map_sub, fetch_r, fetch_nxt, ws_nxt, ws_r, nx_sub;
   logic [2:0]  idx_r, idx_nxt, wi_nxt, wi_r, map_len;
   logic [39:0] wrd_r, wrd_nxt;
   logic        map_valid, map_last, own_match, word_end, rs_pend;
   logic        wr_go, fetch_go, wr_tgl_r, ft_tgl_r;
   logic        rs_tgl_r, rs_seen_r, sda_pos_r, sda_oe_r, sda_out_r;

   // byte k of a word, most significant byte first
   function automatic logic [7:0] pick(input logic [39:0] w, input logic [2:0] len,
                                       input logic [2:0] idx);
      logic [2:0] k;
      k = len - idx - 3'h1;
      return w[{k, 3'b000} +: 8];
   endfunction : pick

   // subaddress low byte is checked before it is stored
   assign map_sub = (st_r == ST_SUBL) ? {sub_r[11:8], byte_in} : sub_r;

   asp_map u_map (
      .sub   (map_sub),
      .valid (map_valid),
      .len   (map_len),
      .last  (map_last)
   );

   assign byte_in   = {sh_r[6:0], SDA_IN};
   assign own_match = byte_in[7:1] == {`ASP_ADDR_HI5, pin_s2_r[3], pin_s2_r[2]};
   assign word_end  = (idx_r == map_len - 3'h1);
   assign rs_pend   = rs_tgl_r ^ rs_seen_r;
   // no advance past the top location
   assign nx_sub    = map_last ? sub_r : sub_r + 12'h001;

   // next-state decisions, taken at each rising SCL edge
   always_comb begin
      st_nxt    = st_r;
      cnt_nxt   = (cnt_r == `ASP_BIT_ACK) ? 4'h0 : cnt_r + 4'h1;
      sh_nxt    = byte_in;
      drv_nxt   = 1'b0;
      rw_nxt    = rw_r;
      sub_nxt   = sub_r;
      idx_nxt   = idx_r;
      ovr_nxt   = ovr_r;
      tx_nxt    = tx_r;
      wrd_nxt   = wrd_r;
      fetch_nxt = fetch_r;
      fetch_go  = 1'b0;
      wr_go     = 1'b0;
      ws_nxt    = ws_r;
      wi_nxt    = wi_r;
      wd_nxt    = wd_r;
      // repeated start: this edge carries address bit 7
      if (rs_pend) begin
         st_nxt  = ST_ADDR;
         cnt_nxt = 4'h1;
         sh_nxt  = {7'h00, SDA_IN};
         ovr_nxt = 1'b0;
      end else begin
         unique case (st_r)
            ST_IDLE: cnt_nxt = cnt_r;
            ST_ADDR: begin
               if (cnt_r == `ASP_BIT_LAST) begin
                  if (own_match) begin
                     drv_nxt = 1'b1;
                     rw_nxt  = SDA_IN;
                  end else begin
                     st_nxt = ST_IDLE;
                  end
               end else if (cnt_r == `ASP_BIT_ACK) begin
                  if (rw_r) begin
                     // read continues from the written subaddress
                     st_nxt    = ST_RDATA;
                     idx_nxt   = 3'h0;
                     wrd_nxt   = rd_word_r;
                     tx_nxt    = pick(rd_word_r, map_len, 3'h0);
                     drv_nxt   = ~tx_nxt[7];
                     fetch_nxt = nx_sub;
                     fetch_go  = 1'b1;
                  end else begin
                     st_nxt = ST_SUBH;
                  end
               end
            end
            ST_SUBH: begin
               if (cnt_r == `ASP_BIT_LAST) begin
                  if (byte_in[7:4] == 4'h0) begin
                     drv_nxt = 1'b1;
                     sub_nxt = {byte_in[3:0], sub_r[7:0]};
                  end else begin
                     st_nxt = ST_IDLE;
                  end
               end else if (cnt_r == `ASP_BIT_ACK) begin
                  st_nxt = ST_SUBL;
               end
            end
            ST_SUBL: begin
               if (cnt_r == `ASP_BIT_LAST) begin
                  if (map_valid) begin
                     drv_nxt   = 1'b1;
                     sub_nxt   = map_sub;
                     idx_nxt   = 3'h0;
                     ovr_nxt   = 1'b0;
                     fetch_nxt = map_sub;
                     fetch_go  = 1'b1;
                  end else begin
                     st_nxt = ST_IDLE;
                  end
               end else if (cnt_r == `ASP_BIT_ACK) begin
                  st_nxt = ST_WDATA;
               end
            end
            ST_WDATA: begin
               if (cnt_r == `ASP_BIT_LAST) begin
                  if (ovr_r) begin
                     // byte past the top is dropped
                     st_nxt = ST_IDLE;
                  end else begin
                     drv_nxt = 1'b1;
                     wr_go   = 1'b1;
                     ws_nxt  = sub_r;
                     wi_nxt  = idx_r;
                     wd_nxt  = byte_in;
                     // advance only at the word boundary
                     if (word_end) begin
                        idx_nxt = 3'h0;
                        if (map_last) ovr_nxt = 1'b1;
                        else sub_nxt = nx_sub;
                     end else begin
                        idx_nxt = idx_r + 3'h1;
                     end
                  end
               end
            end
            ST_RDATA: begin
               if (cnt_r < `ASP_BIT_LAST) begin
                  tx_nxt  = {tx_r[6:0], 1'b0};
                  drv_nxt = ~tx_r[6];
               end else if (cnt_r == `ASP_BIT_ACK) begin
                  if (SDA_IN) begin
                     st_nxt = ST_IDLE;
                  end else if (word_end) begin
                     // next word starts, prefetch the one after
                     idx_nxt   = 3'h0;
                     sub_nxt   = nx_sub;
                     wrd_nxt   = rd_word_r;
                     tx_nxt    = pick(rd_word_r, map_len, 3'h0);
                     drv_nxt   = ~tx_nxt[7];
                     fetch_nxt = (nx_sub == `ASP_SUB_TOP) ? nx_sub : nx_sub + 12'h001;
                     fetch_go  = 1'b1;
                  end else begin
                     idx_nxt = idx_r + 3'h1;
                     tx_nxt  = pick(wrd_r, map_len, idx_r + 3'h1);
                     drv_nxt = ~tx_nxt[7];
                  end
               end
            end
            default: st_nxt = ST_IDLE;
         endcase
      end
   end

   // protocol state, held at the address phase while the link is in reset
   always_ff @(posedge SCL or negedge link_en_r) begin
      if (!link_en_r) begin
         st_r      <= ST_ADDR;
         cnt_r     <= 4'h0;
         sh_r      <= 8'h00;
         rw_r      <= 1'b0;
         sda_pos_r <= 1'b0;
         rs_seen_r <= 1'b0;
      end else begin
         st_r      <= st_nxt;
         cnt_r     <= cnt_nxt;
         sh_r      <= sh_nxt;
         rw_r      <= rw_nxt;
         sda_pos_r <= SDA_IN;
         rs_seen_r <= rs_tgl_r;
      end
   end

   // subaddress pointer survives stops; only device reset clears it
   always_ff @(posedge SCL or negedge rst_n) begin
      if (!rst_n) begin
         sub_r <= 12'h000;
         idx_r <= 3'h0;
         ovr_r <= 1'b0;
      end else begin
         sub_r <= sub_nxt;
         idx_r <= idx_nxt;
         ovr_r <= ovr_nxt;
      end
   end

   // transmit byte, word copy and drive request
   always_ff @(posedge SCL or negedge link_en_r) begin
      if (!link_en_r) begin
         tx_r  <= 8'h00;
         wrd_r <= 40'h0;
         drv_r <= 1'b0;
      end else begin
         tx_r  <= tx_nxt;
         wrd_r <= wrd_nxt;
         drv_r <= drv_nxt;
      end
   end

   // words handed to the system domain, each marked by a toggle
   always_ff @(posedge SCL or negedge rst_n) begin
      if (!rst_n) begin
         wr_tgl_r <= 1'b0;
         ft_tgl_r <= 1'b0;
         ws_r     <= 12'h000;
         wi_r     <= 3'h0;
         wd_r     <= 8'h00;
         fetch_r  <= 12'h000;
      end else begin
         wr_tgl_r <= wr_tgl_r ^ wr_go;
         ft_tgl_r <= ft_tgl_r ^ fetch_go;
         ws_r     <= ws_nxt;
         wi_r     <= wi_nxt;
         wd_r     <= wd_nxt;
         fetch_r  <= fetch_nxt;
      end
   end

   // SDA only pulled low, changed while SCL is low
   // one start per high phase lets a single toggle mark it
   always_ff @(negedge SCL or negedge link_en_r) begin
      if (!link_en_r) begin
         sda_oe_r  <= 1'b0;
         sda_out_r <= 1'b0;
         rs_tgl_r  <= 1'b0;
      end else begin
         sda_oe_r  <= drv_r;
         sda_out_r <= 1'b0;
         if (sda_pos_r && !SDA_IN) rs_tgl_r <= ~rs_tgl_r;
      end
   end

   // -----------------------------------------------------------------
   // system domain: write strobes and read fetches
   // -----------------------------------------------------------------
   // toggles pass two flops; the words beside them hold for a byte time
   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         {wt_s1_r, wt_s2_r, wt_d_r} <= 3'b000;
         {ft_s1_r, ft_s2_r, ft_d_r} <= 3'b000;
      end else begin
         {wt_s1_r, wt_s2_r, wt_d_r} <= {wr_tgl_r, wt_s1_r, wt_s2_r};
         {ft_s1_r, ft_s2_r, ft_d_r} <= {ft_tgl_r, ft_s1_r, ft_s2_r};
      end
   end

   // one-cycle write strobe with its address, byte index and data
   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         wr_stb_r  <= 1'b0;
         wr_addr_r <= 12'h000;
         wr_byte_r <= 3'h0;
         wr_data_r <= 8'h00;
      end else begin
         wr_stb_r <= wt_s2_r ^ wt_d_r;
         if (wt_s2_r ^ wt_d_r) begin
            wr_addr_r <= ws_r;
            wr_byte_r <= wi_r;
            wr_data_r <= wd_r;
         end
      end
   end

   // fetch ahead, so a word waits here before the link needs it
   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         rd_req_r  <= 1'b0;
         rd_addr_r <= 12'h000;
         rd_word_r <= 40'h0;
      end else begin
         rd_req_r <= ft_s2_r ^ ft_d_r;
         if (ft_s2_r ^ ft_d_r) rd_addr_r <= fetch_r;
         if (rd_req_r) rd_word_r <= RD_DATA;
      end
   end

   assign SDA_OE      = sda_oe_r;
   assign SDA_OUT     = sda_out_r;
   assign WR_STROBE   = wr_stb_r;
   assign WR_ADDR     = wr_addr_r;
   assign WR_BYTE     = wr_byte_r;
   assign WR_DATA     = wr_data_r;
   assign RD_REQ      = rd_req_r;
   assign RD_ADDR     = rd_addr_r;
   assign PORT_ACTIVE = link_en_r;

   // -----------------------------------------------------------------
   // assertions
   // -----------------------------------------------------------------
   property p_addr_ack;
      @(posedge SCL) disable iff (!link_en_r)
      (!rs_pend && st_r == ST_ADDR && cnt_r == 4'h7 && own_match)
         |=> drv_r ##1 (rw_r || !drv_r);
   endproperty
   a_addr_ack: assert property (p_addr_ack) else $error("own address not acked");

   property p_addr_miss;
      @(posedge SCL) disable iff (!link_en_r)
      (!rs_pend && st_r == ST_ADDR && cnt_r == 4'h7 && !own_match)
         |=> (st_r == ST_IDLE && !drv_r);
   endproperty
   a_addr_miss: assert property (p_addr_miss) else $error("foreign address kept");

   property p_sub_bad;
      @(posedge SCL) disable iff (!link_en_r)
      (!rs_pend && st_r == ST_SUBL && cnt_r == 4'h7 && !map_valid)
         |=> (st_r == ST_IDLE && !drv_r);
   endproperty
   a_sub_bad: assert property (p_sub_bad) else $error("bad subaddress acked");

   property p_w_ack;
      @(posedge SCL) disable iff (!link_en_r)
      (!rs_pend && st_r == ST_WDATA && cnt_r == 4'h7 && !ovr_r)
         |=> (drv_r && wr_tgl_r != $past(wr_tgl_r));
   endproperty
   a_w_ack: assert property (p_w_ack) else $error("write byte not acked");

   property p_w_ovr;
      @(posedge SCL) disable iff (!link_en_r)
      (!rs_pend && st_r == ST_WDATA && cnt_r == 4'h7 && ovr_r)
         |=> (st_r == ST_IDLE && !drv_r && $stable(wr_tgl_r));
   endproperty
   a_w_ovr: assert property (p_w_ovr) else $error("overrun byte accepted");

   property p_w_inc;
      @(posedge SCL) disable iff (!link_en_r)
      (!rs_pend && st_r == ST_WDATA && cnt_r == 4'h7 && !ovr_r && word_end && !map_last)
         |=> (sub_r == $past(sub_r) + 12'h001 && idx_r == 3'h0);
   endproperty
   a_w_inc: assert property (p_w_inc) else $error("no advance at word end");

   property p_w_hold;
      @(posedge SCL) disable iff (!link_en_r)
      (!rs_pend && st_r == ST_WDATA && cnt_r == 4'h7 && !ovr_r && !word_end)
         |=> ($stable(sub_r) && idx_r == $past(idx_r) + 3'h1);
   endproperty
   a_w_hold: assert property (p_w_hold) else $error("advance inside a word");

   property p_rd_nack;
      @(posedge SCL) disable iff (!link_en_r)
      (!rs_pend && st_r == ST_RDATA && cnt_r == 4'h8 && SDA_IN)
         |=> (st_r == ST_IDLE && !drv_r);
   endproperty
   a_rd_nack: assert property (p_rd_nack) else $error("read kept after nack");

   property p_stop_idle;
      @(posedge MCLK) disable iff (!rst_n)
      stop_det |=> (!link_en_r && !PORT_ACTIVE);
   endproperty
   a_stop_idle: assert property (p_stop_idle) else $error("stop did not idle port");

   property p_start_en;
      @(posedge MCLK) disable iff (!rst_n)
      (start_det && !stop_det && i2c_mode_r) |=> link_en_r;
   endproperty
   a_start_en: assert property (p_start_en) else $error("start not taken");

   property p_no_drive;
      @(posedge MCLK) disable iff (!rst_n)
      (!link_en_r && !$rose(rst_n)) |-> !SDA_OE;
   endproperty
   a_no_drive: assert property (p_no_drive) else $error("SDA driven while idle");

endmodule : asp_i2c_slave

/* File: tb/asp_mst.sv */
// two-wire bus master model: drives scl, pulls sda low
// assumes a pull-up resolves the sda wire outside
`timescale 1ns/1ps
module asp_mst (
   output logic      scl,
   output logic      sda_low,
   input  wire logic sda
);
   // bus idles released; clock stands still between frames
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   // one start per high, also repeated
   task automatic start();
      #8 sda_low = 1'b0;
      #8 scl = 1'b1;
      #40 sda_low = 1'b1;
      #40 scl = 1'b0;
   endtask : start
   // every frame ends with a stop
   task automatic stop();
      #8 sda_low = 1'b1;
      #8 scl = 1'b1;
      #40 sda_low = 1'b0;
      #40;
   endtask : stop
   // one bit: set in low phase, sample after the rise
   task automatic one(input logic b, output logic s);
      #8 sda_low = ~b;
      #7 scl = 1'b1;
      #8 s = sda;
      #7 scl = 1'b0;
   endtask : one
   // eight bits msb first, then the ack slot
   task automatic byte_io(input logic [7:0] tx, input logic ai,
                          output logic [7:0] rx, output logic ao);
      for (int i = 7; i >= 0; i--) begin
         one(tx[i], rx[i]);
      end
      one(ai, ao);
   endtask : byte_io
endmodule : asp_mst

/* File: tb/testbench.sv */
// self-checking bench of the control slave against a master model
// assumes asp_mst as far side and a pull-up on sda
`timescale 1ns/1ps
module testbench;
   logic        MCLK = 1'b0;
   logic        RESETN = 1'b0;
   logic        pl = 1'b0;
   logic        ph = 1'b0;
   logic        bs = 1'b0;
   logic        oe, so, ws, rr, act, scl, m_low, a;
   logic [11:0] wa, ra;
   logic [2:0]  wbi;
   logic [7:0]  wd, rx;
   logic [7:0]  d [6];
   logic [22:0] wq [$];
   logic [31:0] seed = 32'hf4ca;
   int          fails = 0;
   int          total_checks = 0;
   // word store contents derived from the address alone
   function automatic logic [39:0] word(input logic [11:0] s);
      return {4'h0, s, ~s, s};
   endfunction : word
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   wire         sda = ~((oe & ~so) | m_low);
   // the store answers only in the request cycle, so a late sample shows up
   wire  [39:0] rdata = rr ? word(ra) : 40'h0;
   always #4 MCLK = ~MCLK;
   asp_i2c_slave i_dut (.MCLK(MCLK), .RESETN(RESETN), .SCL(scl), .SDA_IN(sda),
      .SDA_OUT(so), .SDA_OE(oe), .SLAVE_ADDR_PIN_LOW(pl), .SLAVE_ADDR_PIN_HIGH(ph),
      .BOOT_SEL(bs), .WR_STROBE(ws), .WR_ADDR(wa), .WR_BYTE(wbi), .WR_DATA(wd),
      .RD_REQ(rr), .RD_ADDR(ra), .RD_DATA(rdata), .PORT_ACTIVE(act));
   asp_mst i_mst (.scl(scl), .sda_low(m_low), .sda(sda));
   // byte writes queued as they leave the port
   always @(posedge MCLK) begin
      if (ws === 1'b1) begin
         wq.push_back({wa, wbi, wd});
      end
   end
   task automatic chk(input logic [22:0] g, input logic [22:0] e);
      total_checks++;
      if (g !== e) begin
         fails++;
         $display("mismatch %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : print_verdict
   task automatic wr(input logic [7:0] v, input logic e);
      i_mst.byte_io(v, 1'b1, rx, a);
      chk(23'(a), 23'(e));
   endtask : wr
   task automatic head(input logic [11:0] s, input logic e);
      i_mst.start();
      wr({5'h0d, ph, pl, 1'b0}, 1'b0);
      wr({4'h0, s[11:8]}, 1'b0);
      wr(s[7:0], e);
   endtask : head
   // missing strobe reads as unknown so it never matches
   task automatic exp_wr(input logic [11:0] s, input int b, input logic [7:0] v);
      chk((wq.size() > 0) ? wq.pop_front() : 23'bx, {s, 3'(b), v});
   endtask : exp_wr
   initial begin
      // random pins and data while reset is held
      for (int i = 0; i < 6; i++) begin
         @(posedge MCLK);
         seed = lfsr(seed);
         d[i] <= seed[7:0];
         pl <= seed[8];
         ph <= seed[9];
      end
      RESETN <= 1'b1;
      repeat (6) @(posedge MCLK);
      head(12'h3ff, 1'b0);
      for (int i = 0; i < 6; i++) wr(d[i], 1'b0);
      i_mst.stop();
      for (int i = 0; i < 6; i++) exp_wr(i < 4 ? 12'h3ff : 12'h400, i % 4, d[i]);
      i_mst.start();
      wr({5'h0d, ~ph, pl, 1'b0}, 1'b1);
      i_mst.stop();
      i_mst.start();
      wr({5'h0d, ph, pl, 1'b0}, 1'b0);
      wr(8'h18, 1'b1);
      i_mst.stop();
      head(12'h700, 1'b1);
      i_mst.stop();
      head(12'h83e, 1'b0);
      for (int i = 0; i < 5; i++) wr(d[i], i == 4);
      i_mst.stop();
      for (int i = 0; i < 4; i++) exp_wr(i < 2 ? 12'h83e : 12'h83f, i % 2, d[i]);
      chk(23'(wq.size()), 23'h0);
      head(12'h83e, 1'b0);
      i_mst.start();
      wr({5'h0d, ph, pl, 1'b1}, 1'b0);
      for (int i = 0; i < 6; i++) begin
         i_mst.byte_io(8'hff, i == 5, rx, a);
         chk(23'(rx), 23'(word(i < 2 ? 12'h83e : 12'h83f) >> (8 * (1 - i % 2)) & 8'hff));
      end
      i_mst.stop();
      #100;
      chk(23'(act), 23'h0);
      // boot strap high: the port stays deaf after a second reset
      @(posedge MCLK);
      RESETN <= 1'b0;
      bs <= 1'b1;
      repeat (6) @(posedge MCLK);
      RESETN <= 1'b1;
      repeat (6) @(posedge MCLK);
      i_mst.start();
      wr({5'h0d, ph, pl, 1'b0}, 1'b1);
      chk(23'(act), 23'h0);
      i_mst.stop();
      print_verdict();
   end
   // hang guard, about twenty times the expected run
   initial begin
      #200000;
      fails++;
      print_verdict();
   end
endmodule : testbench
